// file: sxe_exec.sv
`timescale 1ns/1ps
// How it works
// - left shift: bits up, bit7 to carry, 0 in
// - left shift flags: S Z P result, H N clear
// - left shift code CB then 00100 r, 110=memory
// - arith right: bits down, bit0 carry, keep bit7
// - arith right code CB then 00101 r
// - logical right: 0 into bit7, sign cleared
// - logical right code CB then 00111 r
// - byte subtract: acc minus source, full flags
// - index half field: 100 upper, 101 lower
// - word subtract: pointer pair minus source
// - pair field 001/011/101/111 selects source pair
// - indexed word field 001/011 plus displacement
// - byte indexed base 001/010/011 plus displacement
// - base-index field 001/010/011 adds two registers
// - test-and-set: bit7 to sign, write ones
// - test-and-set memory read uncached, status marked
// - no bus grant between test-and-set read, write
// - input test address: page, high count, low count
// - input test flags only, carry kept
// - inhibit bit set makes input test trap
// - input test code ED then 70
// - exclusive-or: result flags, H N C cleared
module sxe_exec
  import sxe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output sxe_bus_s mem_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_dat_i,
  input wire logic breq_i,
  output logic bgrant_o,
  output logic trap_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] rb [0:7]; // byte registers by field code, 7 is acc
  logic [15:0] ix1_reg, ix2_reg, stk_reg, dsp_reg; // word registers
  logic [7:0] iop_reg, flg_reg, trc_reg; // page, flags, trap control
  logic [23:0] cmd_reg; // prefix, prefix, opcode
  logic pend_reg, trap_st_reg, ill_st_reg; // start request, events
  logic hi_reg; // second byte of a word read
  logic [7:0] lo_reg, hb_reg; // fetched operand bytes
  logic breq_m, breq_s; // request synchroniser
  sxe_state_e state_reg;
  sxe_dec_s dec;
  logic [7:0] b8, res8, fl_n; // operand, result, next flags
  logic [15:0] mpp, srcw_op, w16; // word operands and difference
  logic [8:0] d9; // byte difference with borrow
  logic [16:0] d17; // word difference with borrow
  logic wr, start, exec, inh;
  logic [31:0] rd_val;

  // byte lane merge for wishbone writes
  function automatic logic [7:0] lane(logic [7:0] old, logic [7:0] nw, logic en);
    lane = en ? nw : old;
  endfunction

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign mpp = {rb[4], rb[5]};
  assign exec = (state_reg == ST_EXEC);
  assign inh = trc_reg[TRC_INH];
  assign start = (state_reg == ST_IDLE) && pend_reg && !bgrant_o;

  // instruction decode, one cycle of pure logic
  always_comb begin
    logic [7:0] p0, p1, op;
    logic [2:0] f, g3;
    p0 = cmd_reg[23:16];
    p1 = cmd_reg[15:8];
    op = cmd_reg[7:0];
    f = op[2:0];
    g3 = op[5:3];
    dec = '0;
    dec.kind = K_NONE;
    dec.addr = mpp;
    if (p0 == 8'h00 && p1 == PFX_CB) begin
      // shift group and test-and-set share the CB page
      dec.ok = 1'b1;
      dec.mem = (f == FLD_MEM); // pointer addressed operand
      unique case (op[7:3])
        G_SHL: dec.kind = K_SHL;
        G_ASR: dec.kind = K_ASR;
        G_LSR: dec.kind = K_LSR;
        G_TAS: dec.kind = K_TAS;
        default: dec.ok = 1'b0;
      endcase
    end else if (p0 == 8'h00 && p1 == PFX_ED && op == OP_TIN) begin
      dec.kind = K_TIN;
      dec.ok = 1'b1;
    end else if (p1 == PFX_ED && op[7:6] == 2'b11 && f == FLD_MEM) begin
      dec.kind = K_WSUB;
      if (p0 == 8'h00) begin
        // register pair source
        dec.ok = g3[0];
        unique case (g3)
          3'h1: dec.srcw = {rb[0], rb[1]};
          3'h3: dec.srcw = {rb[2], rb[3]};
          3'h5: dec.srcw = mpp;
          3'h7: dec.srcw = stk_reg;
          default: dec.srcw = 16'h0000;
        endcase
      end else if (p0 == PFX_FD && (g3 == 3'h1 || g3 == 3'h3)) begin
        // indexed word source read from memory
        dec.ok = 1'b1;
        dec.mem = 1'b1;
        dec.word = 1'b1;
        dec.addr = 16'((g3 == 3'h1 ? ix1_reg : ix2_reg) + dsp_reg);
      end
    end else if (p0 == 8'h00 && (op[7:3] == G_SUB || op[7:3] == G_XOR)) begin
      dec.kind = (op[7:3] == G_SUB) ? K_SUB : K_XOR;
      if (p1 == 8'h00) begin
        dec.ok = 1'b1;
        dec.mem = (f == FLD_MEM);
      end else if ((p1 == PFX_DD || p1 == PFX_FD) && (f == 3'h4 || f == 3'h5)) begin
        dec.ok = 1'b1;
        dec.idxh = 1'b1; // half of an index register
      end else if (p1 == PFX_FD && f >= 3'h1 && f <= 3'h3) begin
        dec.ok = 1'b1;
        dec.mem = 1'b1;
        unique case (f)
          3'h1: dec.addr = 16'(ix1_reg + dsp_reg);
          3'h2: dec.addr = 16'(ix2_reg + dsp_reg);
          default: dec.addr = 16'(mpp + dsp_reg);
        endcase
      end else if (p1 == PFX_DD && f >= 3'h1 && f <= 3'h3) begin
        dec.ok = 1'b1;
        dec.mem = 1'b1;
        unique case (f)
          3'h1: dec.addr = 16'(mpp + ix1_reg);
          3'h2: dec.addr = 16'(mpp + ix2_reg);
          default: dec.addr = 16'(ix1_reg + ix2_reg);
        endcase
      end
    end
  end

  // operand select and execution results
  always_comb begin
    logic [15:0] hx;
    hx = (cmd_reg[15:8] == PFX_DD) ? ix1_reg : ix2_reg;
    b8 = rb[cmd_reg[2:0]];
    if (dec.idxh) begin
      b8 = (cmd_reg[2:0] == 3'h4) ? hx[15:8] : hx[7:0];
    end
    if (dec.mem || dec.kind == K_TIN) begin
      b8 = lo_reg;
    end
    srcw_op = dec.word ? {hb_reg, lo_reg} : dec.srcw;
    d9 = {1'b0, rb[7]} - {1'b0, b8};
    d17 = {1'b0, mpp} - {1'b0, srcw_op};
    w16 = d17[15:0];
    res8 = b8;
    fl_n = flg_reg;
    unique case (dec.kind)
      K_SHL: begin
        res8 = {b8[6:0], 1'b0};
        fl_n[F_C] = b8[7];
      end
      K_ASR: begin
        res8 = {b8[7], b8[7:1]};
        fl_n[F_C] = b8[0];
      end
      K_LSR: begin
        res8 = {1'b0, b8[7:1]};
        fl_n[F_C] = b8[0];
      end
      K_SUB: begin
        res8 = d9[7:0];
        fl_n[F_C] = d9[8];
      end
      K_XOR: begin
        res8 = rb[7] ^ b8;
        fl_n[F_C] = 1'b0;
      end
      default: res8 = b8;
    endcase
    // common sign, zero, parity, half, subtract handling
    fl_n[F_S] = res8[7];
    fl_n[F_Z] = (res8 == 8'h00);
    fl_n[F_P] = ~^res8;
    fl_n[F_H] = 1'b0;
    fl_n[F_N] = 1'b0;
    if (dec.kind == K_SUB) begin
      fl_n[F_H] = (rb[7][3:0] < b8[3:0]); // borrow from bit 4
      fl_n[F_P] = (rb[7][7] != b8[7]) && (res8[7] == b8[7]);
      fl_n[F_N] = 1'b1;
    end else if (dec.kind == K_WSUB) begin
      fl_n[F_S] = w16[15];
      fl_n[F_Z] = (w16 == 16'h0000);
      fl_n[F_H] = (mpp[11:0] < srcw_op[11:0]);
      fl_n[F_P] = (mpp[15] != srcw_op[15]) && (w16[15] == srcw_op[15]);
      fl_n[F_N] = 1'b1;
      fl_n[F_C] = d17[16];
    end else if (dec.kind == K_TAS) begin
      res8 = ALL_ONES;
      fl_n = flg_reg;
      fl_n[F_S] = b8[7];
    end
    // input test carry stays, flags from the byte read
  end

  // pin request synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      breq_m <= 1'b0;
      breq_s <= 1'b0;
    end else begin
      breq_m <= breq_i;
      breq_s <= breq_m;
    end
  end

  // grant only while fully idle, so no grant splits a locked pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bgrant_o <= 1'b0;
    end else begin
      bgrant_o <= breq_s && (state_reg == ST_IDLE) && !pend_reg;
    end
  end

  // sequencer and memory / i/o master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      mem_o <= '0;
      hi_reg <= 1'b0;
      lo_reg <= 8'h00;
      hb_reg <= 8'h00;
      trap_o <= 1'b0;
    end else begin
      trap_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start && dec.ok) begin
            if (dec.kind == K_TIN && inh) begin
              trap_o <= 1'b1; // no bus cycle is started
            end else if (dec.kind == K_TIN) begin
              mem_o.cyc <= 1'b1;
              mem_o.io <= 1'b1;
              mem_o.adr <= {iop_reg, rb[0], rb[1]};
              state_reg <= ST_RD;
            end else if (dec.mem) begin
              mem_o.cyc <= 1'b1;
              mem_o.tas <= (dec.kind == K_TAS); // uncached, marked read
              mem_o.adr <= {8'h00, dec.addr};
              hi_reg <= 1'b0;
              state_reg <= ST_RD;
            end else begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_RD: begin
          if (mem_ack_i) begin
            if (dec.word && !hi_reg) begin
              // low byte first, then high byte at the next address
              lo_reg <= mem_dat_i;
              hi_reg <= 1'b1;
              mem_o.adr <= 24'(mem_o.adr + 24'h000001);
            end else begin
              if (hi_reg) begin
                hb_reg <= mem_dat_i;
              end else begin
                lo_reg <= mem_dat_i;
              end
              mem_o.cyc <= 1'b0;
              mem_o.io <= 1'b0;
              mem_o.tas <= 1'b0;
              hi_reg <= 1'b0; // a later input test must not land in the high byte
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (dec.mem && !dec.word && dec.kind != K_SUB && dec.kind != K_XOR) begin
            mem_o.cyc <= 1'b1;
            mem_o.we <= 1'b1;
            mem_o.dat <= res8; // write back shifted or set byte
            state_reg <= ST_WR;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WR: begin
          if (mem_ack_i) begin
            mem_o.cyc <= 1'b0;
            mem_o.we <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // byte register file: execution writes win over software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        rb[i] <= 8'h00;
      end
    end else if (exec && !dec.mem && (dec.kind == K_SHL || dec.kind == K_ASR ||
                 dec.kind == K_LSR || dec.kind == K_TAS)) begin
      rb[cmd_reg[2:0]] <= res8; // register destination
    end else if (exec && (dec.kind == K_SUB || dec.kind == K_XOR)) begin
      rb[7] <= res8; // source untouched
    end else if (exec && dec.kind == K_WSUB) begin
      rb[4] <= w16[15:8];
      rb[5] <= w16[7:0];
    end else if (wr) begin
      unique case (wb_adr_i)
        R_ACC: rb[7] <= lane(rb[7], wb_dat_i[7:0], wb_sel_i[0]);
        R_CNT: begin
          rb[0] <= lane(rb[0], wb_dat_i[15:8], wb_sel_i[1]);
          rb[1] <= lane(rb[1], wb_dat_i[7:0], wb_sel_i[0]);
        end
        R_GP2: begin
          rb[2] <= lane(rb[2], wb_dat_i[15:8], wb_sel_i[1]);
          rb[3] <= lane(rb[3], wb_dat_i[7:0], wb_sel_i[0]);
        end
        R_MPP: begin
          rb[4] <= lane(rb[4], wb_dat_i[15:8], wb_sel_i[1]);
          rb[5] <= lane(rb[5], wb_dat_i[7:0], wb_sel_i[0]);
        end
        default: rb[6] <= rb[6];
      endcase
    end
  end

  // flags: updated by execution, else writable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flg_reg <= FLG_RST;
    end else if (exec) begin
      flg_reg <= fl_n;
    end else if (wr && wb_adr_i == R_FLG && wb_sel_i[0]) begin
      flg_reg <= wb_dat_i[7:0];
    end
  end

  // software-only registers, command and events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ix1_reg, ix2_reg, stk_reg, dsp_reg} <= '0;
      {iop_reg, trc_reg} <= '0;
      cmd_reg <= 24'h000000;
      pend_reg <= 1'b0;
      trap_st_reg <= 1'b0;
      ill_st_reg <= 1'b0;
    end else begin
      if (start) begin
        pend_reg <= 1'b0;
      end
      if (wr) begin
        unique case (wb_adr_i)
          R_CMD: if (!pend_reg && state_reg == ST_IDLE) begin
            cmd_reg <= wb_dat_i[23:0];
            pend_reg <= 1'b1;
          end
          R_IX1: ix1_reg <= wb_dat_i[15:0];
          R_IX2: ix2_reg <= wb_dat_i[15:0];
          R_STK: stk_reg <= wb_dat_i[15:0];
          R_DSP: dsp_reg <= wb_dat_i[15:0];
          R_IOP: iop_reg <= wb_dat_i[7:0];
          R_TRC: trc_reg <= wb_dat_i[7:0];
          R_STA: begin
            if (wb_dat_i[STA_TRAP]) trap_st_reg <= 1'b0;
            if (wb_dat_i[STA_ILL]) ill_st_reg <= 1'b0;
          end
          default: cmd_reg <= cmd_reg;
        endcase
      end
      // a new event wins over a clear in the same cycle
      if (trap_o) trap_st_reg <= 1'b1;
      if (start && !dec.ok) ill_st_reg <= 1'b1;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_val = 32'h00000000;
    unique case (wb_adr_i)
      R_CMD: rd_val = {8'h00, cmd_reg};
      R_ACC: rd_val = {24'h000000, rb[7]};
      R_FLG: rd_val = {24'h000000, flg_reg};
      R_CNT: rd_val = {16'h0000, rb[0], rb[1]};
      R_GP2: rd_val = {16'h0000, rb[2], rb[3]};
      R_MPP: rd_val = {16'h0000, mpp};
      R_IX1: rd_val = {16'h0000, ix1_reg};
      R_IX2: rd_val = {16'h0000, ix2_reg};
      R_STK: rd_val = {16'h0000, stk_reg};
      R_DSP: rd_val = {16'h0000, dsp_reg};
      R_IOP: rd_val = {24'h000000, iop_reg};
      R_TRC: rd_val = {24'h000000, trc_reg};
      R_STA: rd_val = {29'h0, ill_st_reg, trap_st_reg, pend_reg || state_reg != ST_IDLE};
      default: rd_val = 32'h00000000;
    endcase
  end

  // wishbone slave: ack one cycle after the strobe, every address answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_val;
    end
  end

  AST_SHL_CARRY: assert property (
    exec && dec.kind == K_SHL |=> flg_reg[F_C] == $past(b8[7]) && !flg_reg[F_H])
    else $error("left shift carry wrong");
  AST_ASR_TOP: assert property (
    exec && dec.kind == K_ASR |=> flg_reg[F_S] == $past(b8[7]) && flg_reg[F_C] == $past(b8[0]))
    else $error("arith right shift wrong");
  AST_LSR_SIGN: assert property (
    exec && dec.kind == K_LSR |=> !flg_reg[F_S] && flg_reg[F_C] == $past(b8[0]))
    else $error("logical right shift wrong");
  AST_SUB_ACC: assert property (
    exec && dec.kind == K_SUB |=> rb[7] == $past(d9[7:0]) && flg_reg[F_N])
    else $error("byte subtract wrong");
  AST_WSUB_PAIR: assert property (
    exec && dec.kind == K_WSUB |=> mpp == $past(w16) && flg_reg[F_C] == $past(d17[16]))
    else $error("word subtract wrong");
  AST_XOR_CLR: assert property (
    exec && dec.kind == K_XOR |=> flg_reg[F_C] == 1'b0 && flg_reg[F_N] == 1'b0)
    else $error("xor flags wrong");
  AST_TAS_WRITE: assert property (
    exec && dec.kind == K_TAS && dec.mem |=> mem_o.we && mem_o.dat == ALL_ONES)
    else $error("test-and-set write wrong");
  AST_TAS_STATUS: assert property (
    mem_o.cyc && !mem_o.we && !mem_o.io && dec.kind == K_TAS |-> mem_o.tas)
    else $error("test-and-set status missing");
  AST_NO_GRANT: assert property (state_reg != ST_IDLE |-> !bgrant_o)
    else $error("grant during locked sequence");
  AST_IO_ADDR: assert property (
    mem_o.cyc && mem_o.io |-> mem_o.adr == {iop_reg, rb[0], rb[1]})
    else $error("input test address wrong");
  AST_TRAP: assert property (
    start && dec.kind == K_TIN && inh |=> trap_o && !mem_o.cyc ##1 !mem_o.cyc)
    else $error("trap did not block bus");
  COV_TAS_MEM: cover property (exec && dec.kind == K_TAS && dec.mem ##1 state_reg == ST_WR);
  COV_TRAP: cover property (trap_o);
  COV_WSUB_IDX: cover property (exec && dec.kind == K_WSUB && dec.word);
endmodule

// file: sxe_mem_model.sv
`timescale 1ns/1ps
// memory and i/o space on the far side of mem_o, with a back-door port for the bench
module sxe_mem_model
  import sxe_pkg::*;
(
  input wire logic clk_i,
  input wire sxe_bus_s mem_i,
  input wire logic [3:0] wait_i, // idle cycles before each ack
  input wire logic ld_i, // back-door byte load
  input wire logic [7:0] ld_adr_i,
  input wire logic [7:0] ld_dat_i,
  output logic [7:0] peek_o,
  output logic ack_o,
  output logic [7:0] dat_o,
  output logic [23:0] last_adr_o, // address of the latest transfer
  output logic last_tas_o, // test-and-set status seen on the latest read
  output logic last_io_o,
  output logic [7:0] xfer_cnt_o
);
  logic [7:0] mem [0:256-1]; // image wraps on the low address byte
  logic [3:0] wait_cnt;
  assign peek_o = mem[ld_adr_i];
  initial begin
    ack_o = 1'b0;
    dat_o = 8'h00;
    wait_cnt = 4'h0;
    xfer_cnt_o = 8'h00;
  end
  // one ack per transfer; between acks the data lines toggle so stale data never passes
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    dat_o <= ~dat_o;
    if (ld_i)
      mem[ld_adr_i] <= ld_dat_i;
    if (mem_i.cyc && !ack_o) begin
      if (wait_cnt == wait_i) begin
        ack_o <= 1'b1;
        wait_cnt <= 4'h0;
        last_adr_o <= mem_i.adr;
        last_io_o <= mem_i.io;
        xfer_cnt_o <= xfer_cnt_o + 8'h01;
        if (mem_i.we)
          mem[mem_i.adr[7:0]] <= mem_i.dat;
        else begin
          dat_o <= mem[mem_i.adr[7:0]];
          last_tas_o <= mem_i.tas;
        end
      end else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// file: sxe_pkg.sv
package sxe_pkg;
  // register byte addresses on the wishbone slave
  localparam logic [7:0] R_CMD = 8'h00; // command bytes, write starts
  localparam logic [7:0] R_ACC = 8'h04; // accumulator
  localparam logic [7:0] R_FLG = 8'h08; // flag byte
  localparam logic [7:0] R_CNT = 8'h0c; // count pair
  localparam logic [7:0] R_GP2 = 8'h10; // general pair two
  localparam logic [7:0] R_MPP = 8'h14; // memory pointer pair
  localparam logic [7:0] R_IX1 = 8'h18; // first index register
  localparam logic [7:0] R_IX2 = 8'h1c; // second index register
  localparam logic [7:0] R_STK = 8'h20; // stack pointer
  localparam logic [7:0] R_DSP = 8'h24; // 16-bit displacement
  localparam logic [7:0] R_IOP = 8'h28; // i/o page
  localparam logic [7:0] R_TRC = 8'h2c; // trap control
  localparam logic [7:0] R_STA = 8'h30; // status, w1c events
  // flag bit positions
  localparam int F_S = 7;
  localparam int F_Z = 6;
  localparam int F_H = 4;
  localparam int F_P = 2;
  localparam int F_N = 1;
  localparam int F_C = 0;
  // control and status bits
  localparam int TRC_INH = 0; // user i/o inhibit
  localparam int STA_BUSY = 0;
  localparam int STA_TRAP = 1;
  localparam int STA_ILL = 2;
  // opcode encodings
  localparam logic [7:0] PFX_CB = 8'hcb;
  localparam logic [7:0] PFX_ED = 8'hed;
  localparam logic [7:0] PFX_DD = 8'hdd;
  localparam logic [7:0] PFX_FD = 8'hfd;
  localparam logic [7:0] OP_TIN = 8'h70;
  localparam logic [4:0] G_SHL = 5'h04;
  localparam logic [4:0] G_ASR = 5'h05;
  localparam logic [4:0] G_TAS = 5'h06;
  localparam logic [4:0] G_LSR = 5'h07;
  localparam logic [4:0] G_SUB = 5'h12;
  localparam logic [4:0] G_XOR = 5'h15;
  localparam logic [2:0] FLD_MEM = 3'h6;
  localparam logic [7:0] FLG_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_SHL = 4'h1, K_ASR = 4'h2, K_LSR = 4'h3, K_TAS = 4'h4,
    K_SUB = 4'h5, K_XOR = 4'h6, K_WSUB = 4'h7, K_TIN = 4'h8
  } sxe_kind_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RD = 2'b01, ST_EXEC = 2'b10, ST_WR = 2'b11
  } sxe_state_e;
  // decoded instruction
  typedef struct packed {
    sxe_kind_e kind;
    logic ok;
    logic mem;
    logic word;
    logic idxh;
    logic [15:0] addr;
    logic [15:0] srcw;
  } sxe_dec_s;
  // outgoing memory / i/o request
  typedef struct packed {
    logic cyc;
    logic we;
    logic io;
    logic tas;
    logic [23:0] adr;
    logic [7:0] dat;
  } sxe_bus_s;
endpackage

// file: tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module tb
  import sxe_pkg::*;
;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, breq, bgrant, trap, mack, ld, last_tas, last_io, tas_win;
  logic [7:0] wb_adr, mdat, ld_adr, ld_dat, peek, xfer, x0;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [3:0] mwait;
  logic [23:0] last_adr;
  logic [15:0] ea;
  sxe_bus_s mem_bus;
  int n_fail, n_compared, cycles, traps, grant_bad;
  sxe_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hf), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .mem_o(mem_bus), .mem_ack_i(mack), .mem_dat_i(mdat), .breq_i(breq), .bgrant_o(bgrant), .trap_o(trap));
  sxe_mem_model mem_u (.clk_i(clk_i), .mem_i(mem_bus), .wait_i(mwait), .ld_i(ld), .ld_adr_i(ld_adr),
    .ld_dat_i(ld_dat), .peek_o(peek), .ack_o(mack), .dat_o(mdat), .last_adr_o(last_adr),
    .last_tas_o(last_tas), .last_io_o(last_io), .xfer_cnt_o(xfer));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // trap pulses, grants inside a test-and-set window, and the hang limit
  always @(posedge clk_i) begin
    cycles++;
    if (trap === 1'b1)
      traps++;
    if (mem_bus.cyc && mem_bus.tas)
      tas_win <= 1'b1;
    else if (mack && mem_bus.we)
      tas_win <= 1'b0;
    if (tas_win && bgrant !== 1'b0)
      grant_bad++;
    if (cycles == 30000) begin
      n_fail++;
      test_done();
    end
  end
  // one classic wishbone cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    // the ack ends this wait; the cycle ceiling catches a missing one
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // issue a command, optionally raise bus request behind it, poll until idle
  task automatic run(input logic [23:0] cmd, input logic br = 1'b0);
    wr(R_CMD, {8'h00, cmd});
    breq <= br;
    do begin
      rd(R_STA);
    end while (q[STA_BUSY] !== 1'b0);
  endtask
  // back-door access; peek is settled after the second edge
  task automatic load(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ld <= 1'b1;
    ld_adr <= a;
    ld_dat <= d;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask
  function automatic logic [7:0] szp(input logic [7:0] r);
    return {r[7], r == 8'h00, 3'b000, ~^r, 2'b00};
  endfunction
  function automatic logic [7:0] subf(input logic [7:0] a, input logic [7:0] s);
    logic [7:0] r;
    r = a - s;
    return {r[7], r == 8'h00, 1'b0, a[3:0] < s[3:0], 1'b0, (a[7] != s[7]) && (r[7] == s[7]), 1'b1, a < s};
  endfunction
  function automatic logic [7:0] subwf(input logic [15:0] a, input logic [15:0] s);
    logic [15:0] r;
    r = a - s;
    return {r[15], r == 16'h0, 1'b0, a[11:0] < s[11:0], 1'b0, (a[15] != s[15]) && (r[15] == s[15]), 1'b1, a < s};
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] v, r, ops [3], pf [5], sv [5];
    logic [2:0] rf [5];
    logic [15:0] bs [3], ws [4];
    int pa [3], pb [3];
    {rst_i, wb_cyc, wb_stb, wb_we, breq, ld, tas_win} = 7'h40;
    {wb_adr, wb_wdat, ld_adr, ld_dat, mwait} = '0;
    ops = '{8'hb1, 8'h8f, 8'h01};
    pf = '{8'h00, PFX_DD, PFX_DD, PFX_FD, PFX_FD};
    rf = '{3'h0, 3'h4, 3'h5, 3'h4, 3'h5};
    sv = '{8'h48, 8'h01, 8'h90, 8'h30, 8'h0f};
    bs = '{16'h0190, 16'h300f, 16'h0040};
    pa = '{2, 2, 0};
    pb = '{0, 1, 1};
    ws = '{16'h4818, 16'h0010, 16'ha123, 16'hb000};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h3c);
    `CHK(q, 32'h0)
    // each shift on the accumulator and on the pointed-to byte
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 2; m++) begin
        v = ops[(i + m) % 3];
        r = (i == 0) ? {v[6:0], 1'b0} : {(i == 1) & v[7], v[7:1]};
        wr(R_MPP, 32'h40);
        load(8'h40, v);
        wr(R_ACC, {24'h0, v});
        run({PFX_CB, (i == 0) ? G_SHL : (i == 1) ? G_ASR : G_LSR, (m == 1) ? FLD_MEM : 3'h7});
        rd(R_ACC);
        `CHK((m == 1) ? peek : q[7:0], r)
        rd(R_FLG);
        `CHK(q[7:0], szp(r) | ((i == 0) ? v[7] : v[0]))
      end
    end
    $display("shift test done");
    wr(R_CNT, 32'h4818);
    wr(R_IX1, 32'h0190);
    wr(R_IX2, 32'h300f);
    for (int i = 0; i < 5; i++) begin
      wr(R_ACC, 32'h30);
      run({pf[i], G_SUB, rf[i]});
      rd(R_ACC);
      `CHK(q[7:0], 8'h30 - sv[i])
      rd(R_FLG);
      `CHK(q[7:0], subf(8'h30, sv[i]))
    end
    // stale flags must be cleared by the exclusive-or
    wr(R_ACC, 32'h48);
    wr(R_FLG, 32'h13);
    run({8'h00, G_XOR, 3'h1});
    rd(R_FLG);
    `CHK(q[7:0], szp(8'h48 ^ 8'h18))
    $display("byte arithmetic test done");
    wr(R_DSP, 32'h5);
    for (int i = 1; i < 7; i++) begin
      ea = (i < 4) ? bs[i - 1] + 16'h5 : bs[pa[i - 4]] + bs[pb[i - 4]];
      load(ea[7:0], ea[7:0] ^ 8'h5a);
      wr(R_ACC, 32'h0);
      run({(i < 4) ? PFX_FD : PFX_DD, G_XOR, 3'((i < 4) ? i : i - 3)});
      rd(R_ACC);
      `CHK(q[7:0], ea[7:0] ^ 8'h5a)
    end
    $display("indexed operand test done");
    wr(R_GP2, 32'h0010);
    wr(R_STK, 32'hb000);
    for (int i = 0; i < 4; i++) begin
      wr(R_MPP, 32'ha123);
      run({PFX_ED, 2'b11, 3'(2 * i + 1), 3'h6});
      rd(R_MPP);
      `CHK(q[15:0], 16'ha123 - ws[i])
      rd(R_FLG);
      `CHK(q[7:0], subwf(16'ha123, ws[i]))
    end
    // indexed word source: low byte at first index plus displacement, high byte above it
    wr(R_MPP, 32'ha123);
    load(8'h95, 8'h10);
    load(8'h96, 8'h00);
    run({PFX_FD, PFX_ED, 2'b11, 3'h1, 3'h6});
    rd(R_MPP);
    `CHK(q[15:0], 16'ha113)
    $display("word subtract test done");
    // slow memory and a bus request raised while the command runs
    mwait <= 4'h3;
    wr(R_MPP, 32'h40);
    load(8'h40, 8'h17);
    wr(R_FLG, 32'hff);
    run({PFX_CB, G_TAS, FLD_MEM}, 1'b1);
    `CHK(peek, 8'hff)
    rd(R_FLG);
    `CHK(q[7:0], 8'h7f)
    `CHK(last_tas, 1'b1)
    `CHK(grant_bad, 0)
    repeat (6) @(posedge clk_i);
    `CHK(bgrant, 1'b1)
    breq <= 1'b0;
    repeat (6) @(posedge clk_i);
    $display("test-and-set test done");
    mwait <= 4'h1;
    wr(R_CNT, 32'h5046);
    wr(R_IOP, 32'h12);
    load(8'h46, 8'h93);
    wr(R_FLG, 32'h01);
    wr(R_ACC, 32'h55);
    x0 = xfer;
    run({8'h00, PFX_ED, OP_TIN});
    `CHK(last_adr, 24'h125046)
    `CHK(last_io, 1'b1)
    `CHK(xfer - x0, 8'h01)
    rd(R_FLG);
    `CHK(q[7:0], szp(8'h93) | 8'h01)
    rd(R_ACC);
    `CHK(q[7:0], 8'h55)
    wr(R_TRC, 32'h1);
    x0 = xfer;
    traps = 0;
    run({8'h00, PFX_ED, OP_TIN});
    `CHK(traps, 1)
    `CHK(xfer - x0, 8'h00)
    rd(R_STA);
    `CHK(q[STA_TRAP], 1'b1)
    wr(R_TRC, 32'h0);
    run({16'h0000, 8'h76});
    rd(R_STA);
    `CHK(q[STA_ILL], 1'b1)
    $display("input test done");
    test_done();
  end
endmodule
